/* rtl/dtc_sync.sv */
/*
 * Constants for the drive terminal command block, and a two-flop
 * synchroniser for its terminal inputs.
 * Assumes terminal pins are asynchronous to clk_in and that the
 * terminal assignment codes are static while the drive runs.
 */
package dtc_pkg;
  localparam int          NUM_TERM  = 5;
  localparam int          CODE_W    = 11;
  localparam int          NUM_FN    = 8;
  localparam int          SYNC_W    = NUM_TERM + 3;
  // function indices into the decode arrays
  localparam int          FI_RAMP   = 0;
  localparam int          FI_HOLD   = 1;
  localparam int          FI_RST    = 2;
  localparam int          FI_TRIP   = 3;
  localparam int          FI_FSRC   = 4;
  localparam int          FI_DCB    = 5;
  localparam int          FI_MAINS_HANDOVER_LOW   = 6;
  localparam int          FI_MAINS_HANDOVER_HIGH   = 7;
  localparam logic [10:0] FN_RAMP   = 11'h004;
  localparam logic [10:0] FN_HOLD   = 11'h006;
  localparam logic [10:0] FN_RST    = 11'h008;
  localparam logic [10:0] FN_TRIP   = 11'h009;
  localparam logic [10:0] FN_FSRC   = 11'h00B;
  localparam logic [10:0] FN_DCB    = 11'h00D;
  localparam logic [10:0] FN_MAINS_HANDOVER_LOW   = 11'h00F;
  localparam logic [10:0] FN_MAINS_HANDOVER_HIGH   = 11'h010;
  localparam logic [10:0] NEG_OFS   = 11'h3E8;
  localparam logic [7:0]  ALARM_EXT_TRIP = 8'h02;
  localparam logic [7:0]  ALARM_NONE     = 8'h00;
  localparam logic [7:0]  MAINS_LOW_HZ   = 8'h32;
  localparam logic [7:0]  MAINS_HIGH_HZ  = 8'h3C;
  localparam logic [7:0]  FREQ_NONE      = 8'h00;
  localparam int          CLK_HZ         = 25000000;
  localparam int          RST_MIN_MS     = 10;
  localparam int          RST_MIN_CYC    = (CLK_HZ / 1000) * RST_MIN_MS;
  localparam int          RST_CNT_W      = 18;
endpackage

`timescale 1ns/10ps
module dtc_sync (
  input  wire logic                      clk_in,
  input  wire logic                      resetn_in,
  input  wire logic [dtc_pkg::SYNC_W-1:0] d_in,
  output logic      [dtc_pkg::SYNC_W-1:0] q_out
);
  logic [dtc_pkg::SYNC_W-1:0] meta_r;
  logic [dtc_pkg::SYNC_W-1:0] q_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d_in;
      q_r    <= meta_r;
    end
  end

  assign q_out = q_r;
endmodule

/* rtl/dtc_top.sv */
/*
 * Digital terminal command decoder of a motor drive: ramp and source
 * select, two/three-wire run, coast stop, external trip with alarm
 * reset, dc brake hold and mains-to-drive handover start.
 * Assumes one 25 MHz clock, asynchronous pins, static assignment codes.
 */
`timescale 1ns/10ps
module dtc_top #(
  parameter int RST_MIN_CYC = dtc_pkg::RST_MIN_CYC
) (
  input  wire logic                                  clk_in,
  input  wire logic                                  resetn_in,
  input  wire logic [dtc_pkg::NUM_TERM-1:0]          term_in,
  input  wire logic [dtc_pkg::NUM_TERM*dtc_pkg::CODE_W-1:0] term_func_in,
  input  wire logic                                  run_forward_in,
  input  wire logic                                  run_reverse_in,
  input  wire logic                                  coast_stop_in,
  output logic                                       ramp_time_set2_out,
  output logic                                       freq_source2_out,
  output logic                                       run_out,
  output logic                                       run_reverse_dir_out,
  output logic                                       output_enable_out,
  output logic                                       dc_brake_active_out,
  output logic                                       mains_start_out,
  output logic      [7:0]                            mains_freq_hz_out,
  output logic                                       alarm_relay_output_out,
  output logic                                       alarm_display_out,
  output logic      [7:0]                            alarm_code_out
);
  localparam logic [10:0] FN_CODES [dtc_pkg::NUM_FN] = '{
    dtc_pkg::FN_RAMP, dtc_pkg::FN_HOLD, dtc_pkg::FN_RST, dtc_pkg::FN_TRIP,
    dtc_pkg::FN_FSRC, dtc_pkg::FN_DCB, dtc_pkg::FN_MAINS_HANDOVER_LOW, dtc_pkg::FN_MAINS_HANDOVER_HIGH};
  localparam logic [dtc_pkg::RST_CNT_W-1:0] RST_LIM =
    dtc_pkg::RST_CNT_W'(RST_MIN_CYC);

  logic [dtc_pkg::SYNC_W-1:0]     sync_q;
  logic [dtc_pkg::NUM_TERM-1:0]   term_q;
  logic                           fwd_q;
  logic                           rev_q;
  logic                           coast_q;
  logic [dtc_pkg::NUM_FN-1:0]     asg;
  logic [dtc_pkg::NUM_FN-1:0]     act;
  logic [dtc_pkg::NUM_TERM-1:0]   fn_asg [dtc_pkg::NUM_FN];
  logic [dtc_pkg::NUM_TERM-1:0]   fn_act [dtc_pkg::NUM_FN];
  logic                           trip_on;
  logic                           hold_on;
  logic                           fwd_rise;
  logic                           rev_rise;
  logic                           run_cmd;
  logic                           run_dir;
  logic                           rst_fall;
  logic                           rst_rise;
  logic                           blocked;

  logic                           fwd_prev_r, fwd_prev_nxt;
  logic                           rev_prev_r, rev_prev_nxt;
  logic                           hold_valid_r, hold_valid_nxt;
  logic                           hold_rev_r, hold_rev_nxt;
  logic [dtc_pkg::RST_CNT_W-1:0]  rst_cnt_r, rst_cnt_nxt;
  logic                           rst_qual_r, rst_qual_nxt;
  logic                           alarm_hold_r, alarm_hold_nxt;
  logic                           relay_r, relay_nxt;
  logic                           run_prev_r, run_prev_nxt;
  logic                           mains_r, mains_nxt;
  logic                           mains_high_r, mains_high_nxt;
  logic                           ramp_r, ramp_nxt;
  logic                           fsrc_r, fsrc_nxt;
  logic                           run_r, run_nxt;
  logic                           dir_r, dir_nxt;
  logic                           oe_r, oe_nxt;
  logic                           dcb_r, dcb_nxt;
  logic [7:0]                     mhz_r, mhz_nxt;
  logic [7:0]                     acode_r, acode_nxt;

  dtc_sync u_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .d_in      ({coast_stop_in, run_reverse_in, run_forward_in, term_in}),
    .q_out     (sync_q)
  );

  assign term_q  = sync_q[dtc_pkg::NUM_TERM-1:0];
  assign fwd_q   = sync_q[dtc_pkg::NUM_TERM];
  assign rev_q   = sync_q[dtc_pkg::NUM_TERM+1];
  assign coast_q = sync_q[dtc_pkg::NUM_TERM+2];

  // codes of 1000 and up are the active-off form of the same command
  for (genvar i = 0; i < dtc_pkg::NUM_TERM; i++) begin : g_term
    logic [10:0] code;
    logic        neg;
    logic [10:0] base;
    assign code = term_func_in[i*dtc_pkg::CODE_W +: dtc_pkg::CODE_W];
    assign neg  = (code >= dtc_pkg::NEG_OFS);
    assign base = neg ? code - dtc_pkg::NEG_OFS : code;
    for (genvar f = 0; f < dtc_pkg::NUM_FN; f++) begin : g_fn
      assign fn_asg[f][i] = (base == FN_CODES[f]);
      assign fn_act[f][i] = (base == FN_CODES[f]) & (term_q[i] ^ neg);
    end
  end

  for (genvar f = 0; f < dtc_pkg::NUM_FN; f++) begin : g_red
    assign asg[f] = |fn_asg[f];
    assign act[f] = |fn_act[f];
  end

  // enable-trip command: code 9 trips on an open input, 1009 on closed
  assign trip_on  = asg[dtc_pkg::FI_TRIP] & ~act[dtc_pkg::FI_TRIP];
  assign hold_on  = act[dtc_pkg::FI_HOLD];
  assign fwd_rise = fwd_q & ~fwd_prev_r;
  assign rev_rise = rev_q & ~rev_prev_r;
  // a reset shorter than the minimum is treated as noise
  assign rst_rise = rst_qual_nxt & ~rst_qual_r;
  assign rst_fall = rst_qual_r & ~rst_qual_nxt;
  assign blocked  = coast_q | alarm_hold_r | trip_on;

  always_comb begin
    fwd_prev_nxt   = fwd_q;
    rev_prev_nxt   = rev_q;
    hold_valid_nxt = hold_valid_r;
    hold_rev_nxt   = hold_rev_r;
    if (!hold_on) begin
      hold_valid_nxt = 1'b0;
    end else if (!hold_valid_r && (fwd_rise || rev_rise)) begin
      hold_valid_nxt = 1'b1;
      hold_rev_nxt   = rev_rise & ~fwd_rise;
    end
    // both levels on at once means stop in two-wire mode
    if (asg[dtc_pkg::FI_HOLD] && hold_valid_r) begin
      run_cmd = 1'b1;
      run_dir = hold_rev_r;
    end else begin
      run_cmd = fwd_q ^ rev_q;
      run_dir = rev_q;
    end
  end

  always_comb begin
    rst_cnt_nxt  = rst_cnt_r;
    rst_qual_nxt = 1'b0;
    if (act[dtc_pkg::FI_RST]) begin
      if (rst_cnt_r != RST_LIM) begin
        rst_cnt_nxt = rst_cnt_r + 1'b1;
      end
      rst_qual_nxt = (rst_cnt_r == RST_LIM);
    end else begin
      rst_cnt_nxt = '0;
    end
    // a new trip wins over a reset edge in the same cycle
    relay_nxt      = relay_r;
    alarm_hold_nxt = alarm_hold_r;
    if (rst_rise) begin
      relay_nxt = 1'b0;
    end
    if (rst_fall) begin
      alarm_hold_nxt = 1'b0;
    end
    if (trip_on) begin
      relay_nxt      = 1'b1;
      alarm_hold_nxt = 1'b1;
    end
    // code is registered beside the hold flag so both change together
    acode_nxt = alarm_hold_nxt ? dtc_pkg::ALARM_EXT_TRIP :
                dtc_pkg::ALARM_NONE;
  end

  always_comb begin
    run_prev_nxt   = run_cmd;
    mains_nxt      = mains_r;
    mains_high_nxt = mains_high_r;
    if (!run_cmd || blocked) begin
      mains_nxt = 1'b0;
    end else if (!run_prev_r) begin
      mains_nxt      = act[dtc_pkg::FI_MAINS_HANDOVER_LOW] | act[dtc_pkg::FI_MAINS_HANDOVER_HIGH];
      mains_high_nxt = act[dtc_pkg::FI_MAINS_HANDOVER_HIGH];
    end
    ramp_nxt = asg[dtc_pkg::FI_RAMP] & act[dtc_pkg::FI_RAMP];
    fsrc_nxt = asg[dtc_pkg::FI_FSRC] & act[dtc_pkg::FI_FSRC];
    run_nxt  = run_cmd;
    dir_nxt  = run_dir;
    // coast drops the output with no alarm of its own
    oe_nxt   = run_cmd & ~blocked;
    // braking holds whether running or stopped
    dcb_nxt  = act[dtc_pkg::FI_DCB];
    mhz_nxt  = !mains_nxt ? dtc_pkg::FREQ_NONE :
               mains_high_nxt ? dtc_pkg::MAINS_HIGH_HZ :
               dtc_pkg::MAINS_LOW_HZ;
  end

  // all latched run and trip state returns to idle on reset
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fwd_prev_r   <= 1'b0;
      rev_prev_r   <= 1'b0;
      hold_valid_r <= 1'b0;
      hold_rev_r   <= 1'b0;
      rst_cnt_r    <= '0;
      rst_qual_r   <= 1'b0;
      alarm_hold_r <= 1'b0;
      relay_r      <= 1'b0;
      run_prev_r   <= 1'b0;
      mains_r      <= 1'b0;
      mains_high_r <= 1'b0;
      ramp_r       <= 1'b0;
      fsrc_r       <= 1'b0;
      run_r        <= 1'b0;
      dir_r        <= 1'b0;
      oe_r         <= 1'b0;
      dcb_r        <= 1'b0;
      mhz_r        <= dtc_pkg::FREQ_NONE;
      acode_r      <= dtc_pkg::ALARM_NONE;
    end else begin
      fwd_prev_r   <= fwd_prev_nxt;
      rev_prev_r   <= rev_prev_nxt;
      hold_valid_r <= hold_valid_nxt;
      hold_rev_r   <= hold_rev_nxt;
      rst_cnt_r    <= rst_cnt_nxt;
      rst_qual_r   <= rst_qual_nxt;
      alarm_hold_r <= alarm_hold_nxt;
      relay_r      <= relay_nxt;
      run_prev_r   <= run_prev_nxt;
      mains_r      <= mains_nxt;
      mains_high_r <= mains_high_nxt;
      ramp_r       <= ramp_nxt;
      fsrc_r       <= fsrc_nxt;
      run_r        <= run_nxt;
      dir_r        <= dir_nxt;
      oe_r         <= oe_nxt;
      dcb_r        <= dcb_nxt;
      mhz_r        <= mhz_nxt;
      acode_r      <= acode_nxt;
    end
  end

  assign ramp_time_set2_out     = ramp_r;
  assign freq_source2_out       = fsrc_r;
  assign run_out                = run_r;
  assign run_reverse_dir_out    = dir_r;
  assign output_enable_out      = oe_r;
  assign dc_brake_active_out    = dcb_r;
  assign mains_start_out        = mains_r;
  assign mains_freq_hz_out      = mhz_r;
  assign alarm_relay_output_out = relay_r;
  assign alarm_display_out      = alarm_hold_r;
  assign alarm_code_out         = acode_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  property p_ramp_default;
    !asg[dtc_pkg::FI_RAMP] ##1 !asg[dtc_pkg::FI_RAMP] |-> !ramp_time_set2_out;
  endproperty
  a_ramp_default: assert property (p_ramp_default)
    else $error("ramp set 2 without a ramp select terminal");

  property p_fsrc_follow;
    asg[dtc_pkg::FI_FSRC] |=> freq_source2_out == $past(act[dtc_pkg::FI_FSRC]);
  endproperty
  a_fsrc_follow: assert property (p_fsrc_follow)
    else $error("frequency source does not follow its select");

  property p_hold_keep;
    hold_on && hold_valid_r && !fwd_q && !rev_q |=> run_out;
  endproperty
  a_hold_keep: assert property (p_hold_keep)
    else $error("latched run dropped while hold on");

  property p_hold_release;
    !hold_on |=> !hold_valid_r ##1 (run_out == $past(fwd_q ^ rev_q));
  endproperty
  a_hold_release: assert property (p_hold_release)
    else $error("hold off did not release the latch");

  property p_two_wire;
    !asg[dtc_pkg::FI_HOLD] |=> run_out == $past(fwd_q ^ rev_q);
  endproperty
  a_two_wire: assert property (p_two_wire)
    else $error("two-wire run does not follow levels");

  property p_coast;
    coast_q && !trip_on && !alarm_hold_r |=>
      !output_enable_out && !$rose(alarm_relay_output_out);
  endproperty
  a_coast: assert property (p_coast)
    else $error("coast stop left output on or raised alarm");

  property p_trip;
    trip_on |=> alarm_relay_output_out && !output_enable_out
                && alarm_code_out == dtc_pkg::ALARM_EXT_TRIP;
  endproperty
  a_trip: assert property (p_trip)
    else $error("external trip not shown");

  property p_trip_latched;
    (alarm_display_out && !act[dtc_pkg::FI_RST]) [*2] |=> alarm_display_out;
  endproperty
  a_trip_latched: assert property (p_trip_latched)
    else $error("trip cleared without alarm reset");

  property p_reset_relay;
    rst_rise && !trip_on |=> !alarm_relay_output_out;
  endproperty
  a_reset_relay: assert property (p_reset_relay)
    else $error("alarm reset did not clear relay");

  property p_dc_brake;
    act[dtc_pkg::FI_DCB] |=> dc_brake_active_out;
  endproperty
  a_dc_brake: assert property (p_dc_brake)
    else $error("dc brake not active while commanded");

  property p_mains_blocked;
    blocked |=> !mains_start_out;
  endproperty
  a_mains_blocked: assert property (p_mains_blocked)
    else $error("mains start while alarm or coast");

  c_three_wire: cover property (hold_valid_r ##1 !fwd_q && run_out);
  c_trip_reset: cover property (alarm_display_out ##[1:20] !alarm_display_out);
  c_mains: cover property ($rose(mains_start_out) && mains_freq_hz_out ==
                           dtc_pkg::MAINS_HIGH_HZ);
endmodule

/* verif/dtc_relay_model.sv */
/*
 * Behavioural model of the relay sequence that drives the terminal pins.
 * Assumes the bench calls its tasks one at a time from a single process.
 */
`timescale 1ns/10ps
module dtc_relay_model #(
  parameter int RST_HOLD_CYC = 4,
  parameter int LEAD_CYC     = 8,
  parameter int OVERLAP_CYC  = 12,
  parameter int RESTART_MODE = 0
) (
  input  wire logic                    clk_in,
  output logic [dtc_pkg::NUM_TERM-1:0] term_out,
  output logic                         run_forward_out,
  output logic                         run_reverse_out,
  output logic                         coast_stop_out
);
  logic [dtc_pkg::NUM_TERM-1:0] term_r;
  logic                         fwd_r;
  logic                         rev_r;
  logic                         coast_r;

  initial begin
    term_r  = '0;
    fwd_r   = 1'b0;
    rev_r   = 1'b0;
    coast_r = 1'b0;
  end

  assign term_out        = term_r;
  assign run_forward_out = fwd_r;
  assign run_reverse_out = rev_r;
  assign coast_stop_out  = coast_r;

  task automatic set_term(input int idx, input logic val);
    @(posedge clk_in);
    term_r[idx] <= val;
  endtask

  task automatic set_run(input logic run_forward, input logic run_reverse);
    @(posedge clk_in);
    fwd_r <= run_forward;
    rev_r <= run_reverse;
  endtask

  task automatic set_coast(input logic val);
    @(posedge clk_in);
    coast_r <= val;
  endtask

  // press is held past the filter length so the reset is always qualified
  task automatic reset_press(input int idx);
    set_term(idx, 1'b1);
    repeat (RST_HOLD_CYC + 3) @(posedge clk_in);
  endtask

  task automatic reset_release(input int idx);
    set_term(idx, 1'b0);
  endtask

  task automatic handover_on(input int idx);
    set_term(idx, 1'b1);
    if (RESTART_MODE inside {3, 4, 5})
      coast_r <= 1'b1;
    repeat (LEAD_CYC) @(posedge clk_in);
    set_run(1'b1, 1'b0);
  endtask

  // coast goes first so the motor is never left unpowered by the drive
  task automatic handover_off(input int idx);
    repeat (OVERLAP_CYC) @(posedge clk_in);
    set_coast(1'b0);
    set_term(idx, 1'b0);
    set_run(1'b0, 1'b0);
  endtask
endmodule

/* verif/dtc_top_bench.sv */
/*
 * Self-checking bench for the terminal command decoder.
 * Assumes the relay model drives all pins and the bench the codes.
 */
`timescale 1ns/10ps
module dtc_top_bench;
  localparam int RST_CYC = 4;
  logic        clk_in = 1'b0;
  logic        resetn_in;
  logic [54:0] term_func_in;
  logic [4:0]  term;
  logic        run_forward, run_reverse, coast;
  logic        ramp2, fsrc2, run, rdir, oe, dcb, mstart, relay, disp;
  logic [7:0]  mhz, acode;
  int          fail_count = 0;
  int          samples_checked = 0;

  always #20 clk_in = ~clk_in;

  dtc_relay_model #(.RST_HOLD_CYC(RST_CYC)) model_u (
    .clk_in(clk_in), .term_out(term), .run_forward_out(run_forward),
    .run_reverse_out(run_reverse), .coast_stop_out(coast));

  dtc_top #(.RST_MIN_CYC(RST_CYC)) dut_u (
    .clk_in(clk_in), .resetn_in(resetn_in), .term_in(term),
    .term_func_in(term_func_in), .run_forward_in(run_forward),
    .run_reverse_in(run_reverse), .coast_stop_in(coast),
    .ramp_time_set2_out(ramp2), .freq_source2_out(fsrc2),
    .run_out(run), .run_reverse_dir_out(rdir),
    .output_enable_out(oe), .dc_brake_active_out(dcb),
    .mains_start_out(mstart), .mains_freq_hz_out(mhz),
    .alarm_relay_output_out(relay), .alarm_display_out(disp),
    .alarm_code_out(acode));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic chk_byte(input string nm, input logic [7:0] exp,
                          input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // pins need two sync flops and a register stage; sample mid-cycle
  task automatic settle();
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  task automatic set_code(input int idx, input logic [10:0] code);
    @(posedge clk_in);
    term_func_in[idx*11 +: 11] <= code;
  endtask

  task automatic t_select(input logic [10:0] code, input bit fs);
    model_u.set_term(0, 1'b1);
    settle();
    chk_bit("select unassigned", 1'b0, fs ? fsrc2 : ramp2);
    set_code(0, code);
    settle();
    chk_bit("select on", 1'b1, fs ? fsrc2 : ramp2);
    model_u.set_term(0, 1'b0);
    settle();
    chk_bit("select off", 1'b0, fs ? fsrc2 : ramp2);
    set_code(0, 11'h000);
  endtask

  task automatic t_two_wire();
    model_u.set_run(1'b1, 1'b0);
    settle();
    chk_bit("run fwd", 1'b1, run);
    chk_bit("dir fwd", 1'b0, rdir);
    model_u.set_run(1'b0, 1'b1);
    settle();
    chk_bit("dir rev", 1'b1, rdir);
    model_u.set_run(1'b0, 1'b0);
    settle();
    chk_bit("run dropped", 1'b0, run);
  endtask

  task automatic t_three_wire();
    set_code(1, dtc_pkg::FN_HOLD);
    model_u.set_term(1, 1'b1);
    model_u.set_run(1'b0, 1'b1);
    model_u.set_run(1'b0, 1'b0);
    model_u.set_run(1'b1, 1'b0);
    model_u.set_run(1'b0, 1'b0);
    settle();
    chk_bit("held run", 1'b1, run);
    chk_bit("held dir", 1'b1, rdir);
    model_u.set_term(1, 1'b0);
    settle();
    chk_bit("hold released", 1'b0, run);
    set_code(1, 11'h000);
  endtask

  task automatic t_coast();
    model_u.set_run(1'b1, 1'b0);
    settle();
    chk_bit("enable running", 1'b1, oe);
    model_u.set_coast(1'b1);
    settle();
    chk_bit("enable coast", 1'b0, oe);
    chk_bit("relay coast", 1'b0, relay);
    model_u.set_coast(1'b0);
    model_u.set_run(1'b0, 1'b0);
    settle();
  endtask

  task automatic t_dc_brake();
    set_code(2, dtc_pkg::FN_DCB);
    model_u.set_term(2, 1'b1);
    repeat (40) @(posedge clk_in);
    settle();
    chk_bit("brake stopped", 1'b1, dcb);
    model_u.set_term(2, 1'b0);
    settle();
    chk_bit("brake off", 1'b0, dcb);
    set_code(2, 11'h000);
  endtask

  task automatic t_mains(input logic [10:0] code, input logic [7:0] hz);
    set_code(3, code);
    model_u.handover_on(3);
    settle();
    chk_bit("mains start", 1'b1, mstart);
    chk_byte("mains freq", hz, mhz);
    chk_bit("mains enable", 1'b1, oe);
    model_u.handover_off(3);
    settle();
    chk_byte("mains freq idle", dtc_pkg::FREQ_NONE, mhz);
    set_code(3, 11'h000);
  endtask

  task automatic t_mains_coast();
    set_code(3, dtc_pkg::FN_MAINS_HANDOVER_LOW);
    model_u.set_coast(1'b1);
    model_u.handover_on(3);
    settle();
    chk_bit("blocked enable", 1'b0, oe);
    chk_bit("blocked start", 1'b0, mstart);
    model_u.set_coast(1'b0);
    settle();
    chk_bit("late enable", 1'b1, oe);
    chk_bit("late start", 1'b0, mstart);
    model_u.handover_off(3);
    set_code(3, 11'h000);
  endtask

  task automatic t_trip(input logic [10:0] code, input logic lvl);
    int i;
    model_u.set_term(4, !lvl);
    // pin must be through the synchroniser before the trip code is armed
    settle();
    set_code(4, code);
    set_code(1, dtc_pkg::FN_RST);
    model_u.set_run(1'b1, 1'b0);
    settle();
    chk_bit("relay idle", 1'b0, relay);
    model_u.set_term(4, lvl);
    settle();
    chk_bit("trip relay", 1'b1, relay);
    chk_byte("trip code", dtc_pkg::ALARM_EXT_TRIP, acode);
    chk_bit("trip enable", 1'b0, oe);
    model_u.set_term(4, !lvl);
    settle();
    chk_bit("trip latched", 1'b1, relay);
    model_u.reset_press(1);
    for (i = 0; i < RST_CYC + 20 && relay !== 1'b0; i++)
      @(negedge clk_in);
    chk_bit("reset relay", 1'b0, relay);
    chk_bit("display held", 1'b1, disp);
    if (relay !== 1'b0)
      print_verdict();
    model_u.reset_release(1);
    settle();
    chk_bit("display cleared", 1'b0, disp);
    chk_byte("code cleared", dtc_pkg::ALARM_NONE, acode);
    chk_bit("enable restored", 1'b1, oe);
    model_u.set_run(1'b0, 1'b0);
    set_code(4, 11'h000);
    set_code(1, 11'h000);
  endtask

  // mid-run reset must drop a latched trip; code cleared so none re-arms
  task automatic t_reset();
    set_code(4, dtc_pkg::FN_TRIP);
    settle();
    chk_bit("trip before reset", 1'b1, relay);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    set_code(4, 11'h000);
    @(negedge clk_in);
    chk_bit("relay in reset", 1'b0, relay);
    chk_bit("display in reset", 1'b0, disp);
    @(posedge clk_in);
    resetn_in <= 1'b1;
    settle();
    chk_bit("relay after reset", 1'b0, relay);
    chk_byte("code after reset", dtc_pkg::ALARM_NONE, acode);
  endtask

  initial begin
    resetn_in    = 1'b0;
    term_func_in = '0;
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    settle();
    t_select(dtc_pkg::FN_RAMP, 1'b0);
    t_select(dtc_pkg::FN_FSRC, 1'b1);
    t_two_wire();
    t_three_wire();
    t_coast();
    t_dc_brake();
    t_mains(dtc_pkg::FN_MAINS_HANDOVER_LOW, dtc_pkg::MAINS_LOW_HZ);
    t_mains(dtc_pkg::FN_MAINS_HANDOVER_HIGH, dtc_pkg::MAINS_HIGH_HZ);
    t_mains_coast();
    t_trip(dtc_pkg::FN_TRIP, 1'b0);
    t_trip(dtc_pkg::FN_TRIP + dtc_pkg::NEG_OFS, 1'b1);
    t_reset();
    print_verdict();
  end
endmodule
